/* rtl/ldfm_top.sv */
// Fault supervision for a two-string boost LED driver
`timescale 1ns/1ps
`default_nettype none
`include "ldfm_cfg.svh"
module ldfm_top
  import ldfm_pkg::*;
#(
  parameter int N_STRINGS = `LDFM_STRINGS,
  parameter int CLR_CYCLES = `LDFM_CLR_LOW_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic enable_dim_i,
  input wire logic sw_cycle_limit_i,
  input wire logic secondary_switch_current_limit_i,
  input wire logic input_sense_trip_i,
  input wire logic switch_node_ov_i,
  input wire logic output_overvoltage_sense_i,
  input wire logic current_set_pin_short_i,
  input wire logic frequency_set_pin_short_i,
  input wire logic overtemp_i,
  input wire logic undervoltage_lockout_i,
  input wire logic [N_STRINGS-1:0] led_sink_pin_short_i,
  input wire logic [N_STRINGS-1:0] led_sink_pin_open_i,
  input wire logic [N_STRINGS-1:0] led_sink_pin_high_i,
  input wire logic [N_STRINGS-1:0] led_sink_pin_in_reg_i,
  output logic boost_en_o,
  output logic disconnect_gate_en_o,
  output logic [N_STRINGS-1:0] sink_en_o,
  output logic fault_o,
  output logic soft_start_o,
  output logic ov_raise_o
);
  localparam int UV_CYC = `LDFM_UV_FILTER_CYCLES;
  localparam int CW = `LDFM_CLR_CNT_W;
  localparam int UW = `LDFM_UV_CNT_W;
  localparam int SW = `LDFM_CMP_W + 4 * N_STRINGS;

  typedef struct packed {
    ldfm_state_t state;
    logic latch;
    logic [CW-1:0] low_cnt;
    logic [UW-1:0] uv_cnt;
    logic [N_STRINGS-1:0] open_off;
    logic boost;
    logic disc;
    logic [N_STRINGS-1:0] sink;
    logic fault;
    logic soft_start;
    logic ov_raise;
  } ldfm_top_st_t;

  ldfm_top_st_t r_reg;
  ldfm_top_st_t r_next;

  // Refuse sizes that are too small or that the counters cannot hold
  if (N_STRINGS < 1) begin : g_bad_strings
    $error("ldfm_top: N_STRINGS must be at least 1");
  end
  if (CLR_CYCLES < 2 || CLR_CYCLES >= (1 << CW)) begin : g_bad_clear
    $error("ldfm_top: CLR_CYCLES out of range");
  end
  if (UV_CYC < 1 || UV_CYC >= (1 << UW) - 1) begin : g_bad_filter
    $error("ldfm_top: undervoltage filter too long");
  end

  // RULE15 synchronise comparators
  logic [`LDFM_CMP_W-1:0] cmp_raw;
  logic [SW-1:0] sync_raw;
  logic [SW-1:0] sync_s;

  always_comb begin
    cmp_raw = '0;
    cmp_raw[`LDFM_CMP_CYC_LIM] = sw_cycle_limit_i;
    cmp_raw[`LDFM_CMP_SEC_LIM] = secondary_switch_current_limit_i;
    cmp_raw[`LDFM_CMP_SENSE] = input_sense_trip_i;
    cmp_raw[`LDFM_CMP_SW_OV] = switch_node_ov_i;
    cmp_raw[`LDFM_CMP_OUT_OV] = output_overvoltage_sense_i;
    cmp_raw[`LDFM_CMP_CURRENT_SET_PIN] = current_set_pin_short_i;
    cmp_raw[`LDFM_CMP_FREQUENCY_SET_PIN] = frequency_set_pin_short_i;
    cmp_raw[`LDFM_CMP_OT] = overtemp_i;
    cmp_raw[`LDFM_CMP_UV] = undervoltage_lockout_i;
  end

  assign sync_raw = {led_sink_pin_in_reg_i, led_sink_pin_high_i, led_sink_pin_open_i,
                     led_sink_pin_short_i, cmp_raw};

  ldfm_sync #(.W(SW)) ldfm_sync_i (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i(sync_raw),
    .sync_o(sync_s)
  );

  logic cyc_s, lim2_s, sense_s, swov_s, ov_s, current_set_pin_s, frequency_set_pin_s, ot_s, uv_s;
  logic [N_STRINGS-1:0] short_s, open_s, high_s, inreg_s;

  assign cyc_s = sync_s[`LDFM_CMP_CYC_LIM];
  assign lim2_s = sync_s[`LDFM_CMP_SEC_LIM];
  assign sense_s = sync_s[`LDFM_CMP_SENSE];
  assign swov_s = sync_s[`LDFM_CMP_SW_OV];
  assign ov_s = sync_s[`LDFM_CMP_OUT_OV];
  assign current_set_pin_s = sync_s[`LDFM_CMP_CURRENT_SET_PIN];
  assign frequency_set_pin_s = sync_s[`LDFM_CMP_FREQUENCY_SET_PIN];
  assign ot_s = sync_s[`LDFM_CMP_OT];
  assign uv_s = sync_s[`LDFM_CMP_UV];
  assign short_s = sync_s[`LDFM_CMP_W +: N_STRINGS];
  assign open_s = sync_s[`LDFM_CMP_W + N_STRINGS +: N_STRINGS];
  assign high_s = sync_s[`LDFM_CMP_W + 2 * N_STRINGS +: N_STRINGS];
  assign inreg_s = sync_s[`LDFM_CMP_W + 3 * N_STRINGS +: N_STRINGS];

  function automatic logic ldfm_active(input ldfm_state_t st);
    ldfm_active = (st == LDFM_ST_RUN) || (st == LDFM_ST_SEARCH);
  endfunction

  logic set_lat;
  logic shut;
  logic uv_valid;

  always_comb begin
    r_next = r_reg;
    // RULE2 RULE4 RULE5 latch sources
    set_lat = lim2_s | sense_s | swov_s;
    // RULE3 low-time counter
    shut = !enable_dim_i && (r_reg.low_cnt == CW'(CLR_CYCLES - 1));
    // RULE14 glitch filter
    uv_valid = uv_s && (r_reg.uv_cnt == UW'(UV_CYC));
    if (enable_dim_i) begin
      r_next.low_cnt = '0;
    end else if (!shut) begin
      r_next.low_cnt = r_reg.low_cnt + 1'b1;
    end
    if (!uv_s) begin
      r_next.uv_cnt = '0;
    end else if (!uv_valid) begin
      r_next.uv_cnt = r_reg.uv_cnt + 1'b1;
    end
    // RULE13 set wins over clear
    r_next.latch = set_lat | (r_reg.latch & !(shut | uv_valid));

    case (r_reg.state)
      LDFM_ST_OFF: begin
        if (enable_dim_i && !uv_s && !r_reg.latch) begin
          r_next.state = LDFM_ST_START;
        end
      end
      LDFM_ST_START: begin
        // RULE6 hold soft-start
        if (~|short_s && !frequency_set_pin_s && !ot_s) begin
          r_next.state = LDFM_ST_RUN;
        end
      end
      LDFM_ST_RUN: begin
        // RULE7 start open search
        if (|(open_s & ~r_reg.open_off)) begin
          r_next.state = LDFM_ST_SEARCH;
        end
      end
      LDFM_ST_SEARCH: begin
        // RULE7 drop unregulated strings
        if (ov_s) begin
          r_next.open_off = r_reg.open_off | ~inreg_s;
          r_next.state = LDFM_ST_RUN;
        end
      end
      default: begin
        r_next.state = LDFM_ST_OFF;
      end
    endcase

    // RULE9 RULE12 restart through soft-start
    if ((frequency_set_pin_s || ot_s) && r_reg.state != LDFM_ST_OFF) begin
      r_next.state = LDFM_ST_START;
    end
    // RULE13 lockout and shutdown win
    if (uv_valid || shut || r_next.latch) begin
      r_next.state = LDFM_ST_OFF;
    end
    if (r_next.state == LDFM_ST_OFF) begin
      r_next.open_off = '0;
    end

    // RULE1 RULE8 RULE10 boost gating
    r_next.boost = ldfm_active(r_next.state) && !cyc_s && !ov_s && !current_set_pin_s;
    // RULE9 RULE12 disconnect gating
    r_next.disc = (r_next.state != LDFM_ST_OFF) && !frequency_set_pin_s && !ot_s;
    // RULE8 RULE11 per-string sinks; enable low acts as dimming
    r_next.sink = (ldfm_active(r_next.state) && enable_dim_i && !current_set_pin_s)
                  ? ~(r_next.open_off | high_s) : '0;
    // RULE9 flag source
    r_next.fault = r_next.latch | frequency_set_pin_s;
    r_next.soft_start = (r_reg.state == LDFM_ST_START) && (r_next.state == LDFM_ST_RUN);
    r_next.ov_raise = (r_next.state == LDFM_ST_SEARCH);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '{state: LDFM_ST_OFF, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign boost_en_o = r_reg.boost;
  assign disconnect_gate_en_o = r_reg.disc;
  assign sink_en_o = r_reg.sink;
  assign fault_o = r_reg.fault;
  assign soft_start_o = r_reg.soft_start;
  assign ov_raise_o = r_reg.ov_raise;

  property p_cyc_blank;
    @(posedge mclk_i) disable iff (rst_i)
      (cyc_s && !set_lat && !frequency_set_pin_s && !r_reg.latch) |=> !boost_en_o && !fault_o;
  endproperty
  a_cyc_blank: assert property (p_cyc_blank) else $error("cycle limit did not blank boost"); // RULE1

  property p_sec_lim;
    @(posedge mclk_i) disable iff (rst_i)
      lim2_s |=> !boost_en_o && !disconnect_gate_en_o && sink_en_o == '0 && fault_o;
  endproperty
  a_sec_lim: assert property (p_sec_lim) else $error("secondary limit did not shut down"); // RULE2

  property p_latch_clear;
    @(posedge mclk_i) disable iff (rst_i)
      $fell(r_reg.latch) |-> $past(shut) || $past(uv_valid);
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch cleared without cause"); // RULE3

  property p_latch_hold;
    @(posedge mclk_i) disable iff (rst_i)
      (r_reg.latch && enable_dim_i && !uv_valid) |=> r_reg.latch;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch cleared while enable high"); // RULE3

  property p_sense_trip;
    @(posedge mclk_i) disable iff (rst_i)
      sense_s |=> !boost_en_o && !disconnect_gate_en_o && sink_en_o == '0 && fault_o && r_reg.latch;
  endproperty
  a_sense_trip: assert property (p_sense_trip) else $error("sense trip did not shut down"); // RULE4

  property p_sw_ov;
    @(posedge mclk_i) disable iff (rst_i)
      swov_s |=> r_reg.latch && sink_en_o == '0 && !disconnect_gate_en_o && fault_o;
  endproperty
  a_sw_ov: assert property (p_sw_ov) else $error("switch node overvoltage not latched"); // RULE5

  property p_short_hold;
    @(posedge mclk_i) disable iff (rst_i)
      (r_reg.state == LDFM_ST_START && |short_s) |=> !soft_start_o && !boost_en_o;
  endproperty
  a_short_hold: assert property (p_short_hold) else $error("soft-start ran with shorted pin"); // RULE6

  property p_open_drop;
    @(posedge mclk_i) disable iff (rst_i)
      (r_reg.state == LDFM_ST_SEARCH && ov_s) |=> (sink_en_o & ~$past(inreg_s)) == '0;
  endproperty
  a_open_drop: assert property (p_open_drop) else $error("unregulated string left on"); // RULE7

  property p_current_set_pin;
    @(posedge mclk_i) disable iff (rst_i)
      current_set_pin_s |=> !boost_en_o && sink_en_o == '0;
  endproperty
  a_current_set_pin: assert property (p_current_set_pin) else $error("current-set short did not stop boost"); // RULE8

  property p_frequency_set_pin;
    @(posedge mclk_i) disable iff (rst_i)
      frequency_set_pin_s |=> !disconnect_gate_en_o && !boost_en_o && fault_o;
  endproperty
  a_frequency_set_pin: assert property (p_frequency_set_pin) else $error("frequency-set short not handled"); // RULE9

  property p_out_ov;
    @(posedge mclk_i) disable iff (rst_i)
      ov_s |=> !boost_en_o;
  endproperty
  a_out_ov: assert property (p_out_ov) else $error("boost ran during overvoltage"); // RULE10

  property p_led_high;
    @(posedge mclk_i) disable iff (rst_i)
      high_s[0] |=> !sink_en_o[0];
  endproperty
  a_led_high: assert property (p_led_high) else $error("high sink pin string left on"); // RULE11

  property p_ot;
    @(posedge mclk_i) disable iff (rst_i)
      (ot_s && !set_lat && !frequency_set_pin_s && !r_reg.latch) |=> !boost_en_o && !disconnect_gate_en_o && !fault_o;
  endproperty
  a_ot: assert property (p_ot) else $error("overtemperature not handled"); // RULE12

  property p_uv_clear;
    @(posedge mclk_i) disable iff (rst_i)
      (uv_valid && !set_lat) |=> !r_reg.latch && !disconnect_gate_en_o;
  endproperty
  a_uv_clear: assert property (p_uv_clear) else $error("lockout did not clear latch"); // RULE13

  property p_uv_filter;
    @(posedge mclk_i) disable iff (rst_i)
      !uv_s ##1 uv_s [*8] |-> !uv_valid;
  endproperty
  a_uv_filter: assert property (p_uv_filter) else $error("lockout accepted too early"); // RULE14

  property p_sync_delay;
    @(posedge mclk_i) disable iff (rst_i)
      secondary_switch_current_limit_i |-> ##3 fault_o;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("secondary limit latency wrong"); // RULE15
endmodule // ldfm_top
`default_nettype wire

/* rtl/ldfm_cfg.svh */
// Constants of the LED driver fault manager
// Summary of operation
// RULE1: Cycle current limit blanks boost for one cycle; disconnect, sinks, flag untouched.
// RULE2: Secondary switch limit latches everything off and raises the fault flag.
// RULE3: Latched fault clears after enable input stays low 32750 cycles, or on a valid undervoltage lockout.
// RULE4: Input sense trip latches everything off and raises the fault flag.
// RULE5: Switch node overvoltage latches everything off and raises the fault flag.
// RULE6: At startup a shorted sink pin holds soft-start; disconnect on, no flag.
// RULE7: Open pin: raise output to overvoltage, drop unregulated strings, resume.
// RULE8: Current-set short stops boost and sinks, disconnect stays on, no flag.
// RULE9: Frequency-set short turns all off with flag; restarts via soft-start.
// RULE10: Output overvoltage halts boost only while tripped; no flag.
// RULE11: Sink pin above 5.1 V removes only that string; no flag.
// RULE12: Overtemperature turns all off without flag; restarts when cleared.
// RULE13: Undervoltage lockout turns all off without flag and clears latched faults.
// RULE14: Undervoltage counts only after more than 50 us below threshold.
// RULE15: Comparator inputs are synchronised before use; latches act at next edge.
`ifndef LDFM_CFG_SVH
`define LDFM_CFG_SVH

`define LDFM_MCLK_MHZ 50
`define LDFM_STRINGS 2
`define LDFM_CLR_LOW_CYCLES 32750
`define LDFM_CLR_CNT_W 16
`define LDFM_UV_FILTER_NS 50000
`define LDFM_UV_FILTER_CYCLES ((`LDFM_UV_FILTER_NS * `LDFM_MCLK_MHZ + 999) / 1000)
`define LDFM_UV_CNT_W 12

// Positions in the packed comparator vector
`define LDFM_CMP_CYC_LIM 0
`define LDFM_CMP_SEC_LIM 1
`define LDFM_CMP_SENSE 2
`define LDFM_CMP_SW_OV 3
`define LDFM_CMP_OUT_OV 4
`define LDFM_CMP_CURRENT_SET_PIN 5
`define LDFM_CMP_FREQUENCY_SET_PIN 6
`define LDFM_CMP_OT 7
`define LDFM_CMP_UV 8
`define LDFM_CMP_W 9

`endif

/* rtl/ldfm_pkg.sv */
// Types shared by the LED driver fault manager
package ldfm_pkg;
  typedef enum logic [3:0] {
    LDFM_ST_OFF    = 4'b0001,
    LDFM_ST_START  = 4'b0010,
    LDFM_ST_RUN    = 4'b0100,
    LDFM_ST_SEARCH = 4'b1000
  } ldfm_state_t;
endpackage

/* rtl/ldfm_sync.sv */
// Two-stage synchroniser for comparator levels
`timescale 1ns/1ps
`default_nettype none
module ldfm_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ldfm_sync_st_t;

  ldfm_sync_st_t s_reg;
  ldfm_sync_st_t s_next;

  if (W < 1) begin : g_bad_width
    $error("ldfm_sync: W must be at least 1");
  end

  always_comb begin
    s_next.meta = async_i;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_o = s_reg.stable;
endmodule // ldfm_sync
`default_nettype wire

/* tb/ldfm_host.sv */
// Host model that drives the enable/dimming input
`timescale 1ns/1ps
`default_nettype none
module ldfm_host (
  input wire logic mclk_i,
  output logic enable_dim_o
);
  initial enable_dim_o = 1'b0;
  // holds enable level
  // Level changes just after the edge, held for n edges
  task automatic drive(input logic v, input int n);
    enable_dim_o = v;
    repeat (n) @(posedge mclk_i) #1;
  endtask
endmodule // ldfm_host
`default_nettype wire

/* tb/ldfm_top_test.sv */
// Self-checking bench of the LED driver fault manager
`timescale 1ns/1ps
`default_nettype none
module ldfm_top_test;
  import ldfm_pkg::*;
  localparam int CLR = 16;
  logic mclk_i, rst_i, cyc, sec, sns, swov, oov, current_set_pin, frequency_set_pin, ot, uv, en;
  logic boost, disc, flt, ss, ovr;
  logic [1:0] shrt, opn, hi, inreg, sink;
  int fails, num_checks;

  ldfm_host ldfm_host_i (.mclk_i(mclk_i), .enable_dim_o(en));
  ldfm_top #(.N_STRINGS(2), .CLR_CYCLES(CLR)) ldfm_top_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .enable_dim_i(en), .sw_cycle_limit_i(cyc),
    .secondary_switch_current_limit_i(sec), .input_sense_trip_i(sns), .switch_node_ov_i(swov),
    .output_overvoltage_sense_i(oov), .current_set_pin_short_i(current_set_pin), .frequency_set_pin_short_i(frequency_set_pin),
    .overtemp_i(ot), .undervoltage_lockout_i(uv), .led_sink_pin_short_i(shrt), .led_sink_pin_open_i(opn),
    .led_sink_pin_high_i(hi), .led_sink_pin_in_reg_i(inreg), .boost_en_o(boost),
    .disconnect_gate_en_o(disc), .sink_en_o(sink), .fault_o(flt), .soft_start_o(ss), .ov_raise_o(ovr));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // Packed as boost, disconnect, sink[1:0], fault
  function automatic logic [4:0] outs();
    return {boost, disc, sink, flt};
  endfunction

  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %b, expected %b", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i) #1;
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Bounded wait for the soft-start pulse, then let RUN settle
  task automatic wait_run();
    int k;
    k = 0;
    while (ss !== 1'b1 && k < 60) begin
      tick(1);
      k++;
    end
    if (ss !== 1'b1) begin
      chk({4'b0000, ss}, 5'b00001);
      wrap_up();
    end
    tick(2);
  endtask

  task automatic set_cmp(input int i, input logic v);
    case (i)
      1: sec = v;
      2: sns = v;
      3: swov = v;
      4: oov = v;
      5: current_set_pin = v;
      6: frequency_set_pin = v;
      7: ot = v;
      default: uv = v;
    endcase
  endtask

  task automatic t_start();
    shrt = 2'b01;
    // Short must be through the synchroniser before START is entered
    tick(2);
    ldfm_host_i.drive(1'b1, 8);
    chk(outs(), 5'b01000);
    shrt = 2'b00;
    wait_run();
    chk(outs(), 5'b11110);
    $display("Test startup short done");
  endtask

  // Comparator seen three edges later, so one cycle of limit blanks one cycle
  task automatic t_cyc();
    cyc = 1'b1;
    tick(1);
    cyc = 1'b0;
    tick(2);
    chk(outs(), 5'b01110);
    tick(1);
    chk(outs(), 5'b11110);
    $display("Test cycle limit done");
  endtask

  task automatic t_hi();
    hi = 2'b01;
    tick(4);
    chk(outs(), 5'b11100);
    hi = 2'b00;
    tick(4);
    chk(outs(), 5'b11110);
    $display("Test pin high done");
  endtask

  task automatic t_auto(input int i, input logic [4:0] on, input logic sst);
    set_cmp(i, 1'b1);
    tick(4);
    chk(outs(), on);
    set_cmp(i, 1'b0);
    if (sst)
      wait_run();
    else
      tick(4);
    chk(outs(), 5'b11110);
    $display("Test auto fault %0d done", i);
  endtask

  task automatic t_latch(input int i);
    set_cmp(i, 1'b1);
    tick(4);
    chk(outs(), 5'b00001);
    set_cmp(i, 1'b0);
    tick(4);
    chk(outs(), 5'b00001);
    ldfm_host_i.drive(1'b0, CLR - 1);
    ldfm_host_i.drive(1'b1, 4);
    chk(outs(), 5'b00001);
    ldfm_host_i.drive(1'b0, CLR);
    chk(outs(), 5'b00000);
    ldfm_host_i.drive(1'b1, 1);
    chk(outs(), 5'b01000);
    wait_run();
    chk(outs(), 5'b11110);
    $display("Test latched fault %0d done", i);
  endtask

  // A short dip must be ignored; a long one unlatches everything
  task automatic t_uv();
    set_cmp(1, 1'b1);
    tick(4);
    set_cmp(1, 1'b0);
    uv = 1'b1;
    tick(2400);
    uv = 1'b0;
    tick(4);
    chk(outs(), 5'b00001);
    uv = 1'b1;
    tick(2498);
    chk(outs(), 5'b00001);
    tick(10);
    chk(outs(), 5'b00000);
    uv = 1'b0;
    wait_run();
    chk(outs(), 5'b11110);
    $display("Test undervoltage done");
  endtask

  task automatic t_open();
    opn = 2'b10;
    inreg = 2'b01;
    tick(4);
    chk({3'b000, ovr, boost}, 5'b00011);
    oov = 1'b1;
    tick(6);
    chk({2'b00, sink, ovr}, 5'b00010);
    oov = 1'b0;
    opn = 2'b00;
    inreg = 2'b11;
    tick(4);
    chk(outs(), 5'b11010);
    $display("Test open pin done");
  endtask

  initial begin
    fails = 0;
    num_checks = 0;
    {cyc, sec, sns, swov, oov, current_set_pin, frequency_set_pin, ot, uv} = 9'h000;
    {shrt, opn, hi} = 6'h00;
    inreg = 2'b11;
    rst_i = 1'b1;
    tick(6);
    rst_i = 1'b0;
    t_start();
    t_cyc();
    t_hi();
    t_auto(4, 5'b01110, 1'b0);
    t_auto(5, 5'b01000, 1'b0);
    t_auto(6, 5'b00001, 1'b1);
    t_auto(7, 5'b00000, 1'b1);
    t_latch(1);
    t_latch(2);
    t_latch(3);
    t_uv();
    t_open();
    wrap_up();
  end
endmodule // ldfm_top_test
`default_nettype wire
